// ### sim/lmr_lane_map_asserts.sv
`timescale 1ns/10ps
module lmr_lane_map_asserts #(
    parameter int DATA_W = 12,
    parameter logic [63:0] CODE_LUT = 64'h3210_3210_3210_3210,
    parameter logic [43:0] DEFAULT_SEL = 44'h3_10_3322_1100
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire lmr_pkg::lmr_bus_t i_bus,
    input wire logic [4*DATA_W-1:0] i_low_ch_data,
    input wire logic [4*DATA_W-1:0] i_high_ch_data,
    input wire logic [lmr_pkg::REG_W-1:0] o_rdata,
    input wire logic [lmr_pkg::NUM_PAIRS*DATA_W-1:0] o_pair_data,
    input wire logic [lmr_pkg::NUM_PAIRS*lmr_pkg::SEL_W-1:0] o_pair_sel
);
    logic [15:0] sh_ff [4];
    logic [4*DATA_W-1:0] low_ff;
    logic [1:0] age_ff;
    // Outputs lag the register file by one edge, so the first edges are skipped.
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sh_ff <= '{default: 16'h0000};
            age_ff <= 2'h0;
        end else begin
            if (i_bus.wr && i_bus.addr[7:2] == 6'h14) sh_ff[i_bus.addr[1:0]] <= i_bus.wdata;
            if (age_ff != 2'h3) age_ff <= age_ff + 2'h1;
        end
    end
    always_ff @(posedge i_clock) low_ff <= i_low_ch_data;
    function automatic logic [1:0] exp_sel(input logic [15:0] r, input int f, input int p);
        return r[15] ? CODE_LUT[r[f*4 +: 4]*4 +: 2] : DEFAULT_SEL[p*4 +: 2];
    endfunction : exp_sel
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst || age_ff < 2'h2);
    a_sel_pair_1a: assert property (
        o_pair_sel[1:0] == exp_sel($past(sh_ff[0]), 0, 0)) else $error("pair 1A select");
    a_sel_pair_2a: assert property (
        o_pair_sel[9:8] == exp_sel($past(sh_ff[0]), 2, 2)) else $error("pair 2A select");
    a_sel_pair_2b: assert property (
        o_pair_sel[13:12] == exp_sel($past(sh_ff[1]), 0, 3)) else $error("pair 2B select");
    a_sel_pair_4a: assert property (
        o_pair_sel[25:24] == exp_sel($past(sh_ff[2]), 0, 6)) else $error("pair 4A select");
    a_sel_pair_5b: assert property (
        o_pair_sel[37:36] == exp_sel($past(sh_ff[3]), 0, 9)) else $error("pair 5B select");
    a_sel_pair_6b: assert property (
        o_pair_sel[41:40] == exp_sel($past(sh_ff[3]), 2, 10)) else $error("pair 6B select");
    a_mask_wide: assert property (i_bus.rd |=> o_rdata[14:12] == 3'h0)
        else $error("reserved bits read back");
    a_mask_narrow: assert property (
        i_bus.rd && i_bus.addr == 8'h52 |=> o_rdata[14:8] == 7'h00) else $error("narrow bits");
    a_data_low: assert property ($stable(o_pair_sel) |->
        o_pair_data[DATA_W-1:0] == low_ff[o_pair_sel[1:0]*DATA_W +: DATA_W]) else $error("1A data");
endmodule : lmr_lane_map_asserts
bind lmr_lane_map lmr_lane_map_asserts #(
    .DATA_W(DATA_W), .CODE_LUT(CODE_LUT), .DEFAULT_SEL(DEFAULT_SEL)) u_chk (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_bus(i_bus), .i_low_ch_data(i_low_ch_data),
    .i_high_ch_data(i_high_ch_data), .o_rdata(o_rdata), .o_pair_data(o_pair_data),
    .o_pair_sel(o_pair_sel));

// ### sim/lmr_lane_map_bench.sv
`timescale 1ns/10ps
module lmr_lane_map_bench;
    localparam logic [63:0] LUT = 64'h0123_3210_1302_2031;
    localparam logic [43:0] DEF = 44'h3_10_3322_1100;
    localparam int RG[11] = '{0, 0, 0, 1, 1, 1, 2, 2, 3, 3, 3};
    localparam int FL[11] = '{0, 1, 2, 0, 1, 2, 0, 1, 1, 0, 2};
    localparam logic [7:0] AD[10] = '{8'h54, 8'h50, 8'h50, 8'h51, 8'h52, 8'h53, 8'h52,
        8'h53, 8'h50, 8'h51};
    localparam logic [15:0] WD[10] = '{16'hFFFF, 16'h0123, 16'h85A1, 16'h8C4E, 16'h8097,
        16'h86B2, 16'h0097, 16'h0AB2, 16'h0000, 16'h80F3};
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    lmr_pkg::lmr_bus_t bus = '0;
    logic [47:0] low = {12'h4C4, 12'h3B3, 12'h2A2, 12'h111};
    logic [47:0] high = {12'h8F8, 12'h7E7, 12'h6D6, 12'h5C5};
    logic [15:0] rdata;
    logic [131:0] pdata;
    logic [43:0] psel;
    logic [15:0] mdl [4] = '{default: 16'h0000};
    int mismatches = 0;
    int samples_checked = 0;
    always #50 i_clock = ~i_clock;
    lmr_lane_map #(.CODE_LUT(LUT), .DEFAULT_SEL(DEF)) u_dut (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .i_bus(bus), .i_low_ch_data(low), .i_high_ch_data(high),
        .o_rdata(rdata), .o_pair_data(pdata), .o_pair_sel(psel));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        if (a == 8'h52) mdl[2] = d & lmr_pkg::MASK_NARROW;
        else if (a[7:2] == 6'h14) mdl[a[1:0]] = d & lmr_pkg::MASK_WIDE;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_clock);
        bus.rd <= 1'b0;
        #1 chk(rdata, (a[7:2] == 6'h14) ? mdl[a[1:0]] : 16'h0000);
    endtask : rd
    // Every pair is compared on select and on data, defaults included.
    task automatic check_all();
        logic [15:0] r;
        logic [1:0] e;
        for (int p = 0; p < 11; p++) begin
            r = mdl[RG[p]];
            e = r[15] ? LUT[r[FL[p]*4 +: 4]*4 +: 2] : DEF[p*4 +: 2];
            chk({12'h0, psel[p*4 +: 4]}, {14'h0, e});
            chk({4'h0, pdata[p*12 +: 12]}, {4'h0, 12'((p < 8 ? low : high) >> (e * 12))});
        end
    endtask : check_all
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            wr(AD[i], WD[i]);
            rd(AD[i]);
            check_all();
        end
        end_of_test();
    end
endmodule : lmr_lane_map_bench

// ### verilog/lmr_lane_map.sv
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
// Register bank steering channel data onto LVDS output pairs.
// Pairs 1A..4B choose among channels 1-4, pairs 5A, 5B, 6B among 5-8.
module lmr_lane_map #(
    parameter int DATA_W = 12,
    // Code-to-channel lookup: entry k holds the channel index (0..3) for code k.
    parameter logic [63:0] CODE_LUT = 64'h3210_3210_3210_3210,
    // Default channel index per pair (pair 0 in low nibble).
    parameter logic [43:0] DEFAULT_SEL = 44'h3_10_3322_1100
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire lmr_pkg::lmr_bus_t i_bus,
    input wire logic [4*DATA_W-1:0] i_low_ch_data,
    input wire logic [4*DATA_W-1:0] i_high_ch_data,
    output logic [lmr_pkg::REG_W-1:0] o_rdata,
    output logic [lmr_pkg::NUM_PAIRS*DATA_W-1:0] o_pair_data,
    output logic [lmr_pkg::NUM_PAIRS*lmr_pkg::SEL_W-1:0] o_pair_sel
);

////////////////////////////////////////////////////////////////////////////////

    logic [lmr_pkg::REG_W-1:0] map_a1_ff, map_a2_ff, map_a3_ff, map_b1_ff;
    logic [lmr_pkg::REG_W-1:0] nxt_map_a1, nxt_map_a2, nxt_map_a3, nxt_map_b1;
    logic [lmr_pkg::REG_W-1:0] rdata_ff, nxt_rdata;

    // Must-be-zero bits are not stored, so a careless write cannot leak into them.
    always_comb begin
        nxt_map_a1 = map_a1_ff;
        nxt_map_a2 = map_a2_ff;
        nxt_map_a3 = map_a3_ff;
        nxt_map_b1 = map_b1_ff;
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                lmr_pkg::OFS_MAP_A1: nxt_map_a1 = i_bus.wdata & lmr_pkg::MASK_WIDE; // [RQ4]
                lmr_pkg::OFS_MAP_A2: nxt_map_a2 = i_bus.wdata & lmr_pkg::MASK_WIDE; // [RQ4]
                lmr_pkg::OFS_MAP_A3: nxt_map_a3 = i_bus.wdata & lmr_pkg::MASK_NARROW; // [RQ3]
                lmr_pkg::OFS_MAP_B1: nxt_map_b1 = i_bus.wdata & lmr_pkg::MASK_WIDE; // [RQ4]
                default: ;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero.
    always_comb begin
        nxt_rdata = '0;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                lmr_pkg::OFS_MAP_A1: nxt_rdata = map_a1_ff;
                lmr_pkg::OFS_MAP_A2: nxt_rdata = map_a2_ff;
                lmr_pkg::OFS_MAP_A3: nxt_rdata = map_a3_ff;
                lmr_pkg::OFS_MAP_B1: nxt_rdata = map_b1_ff;
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            map_a1_ff <= lmr_pkg::RESET_VAL;
            map_a2_ff <= lmr_pkg::RESET_VAL;
            map_a3_ff <= lmr_pkg::RESET_VAL;
            map_b1_ff <= lmr_pkg::RESET_VAL;
            rdata_ff <= lmr_pkg::RESET_VAL;
        end else begin
            map_a1_ff <= nxt_map_a1;
            map_a2_ff <= nxt_map_a2;
            map_a3_ff <= nxt_map_a3;
            map_b1_ff <= nxt_map_b1;
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_rdata = rdata_ff;

////////////////////////////////////////////////////////////////////////////////

    // Effective fields: a register with its enable clear contributes nothing.
    logic en_a1, en_a2, en_a3, en_b1;
    logic [lmr_pkg::REG_W-1:0] eff_a1, eff_a2, eff_a3, eff_b1;
    logic [lmr_pkg::SEL_W-1:0] low_group_sel_pair_1a, low_group_sel_pair_1b;
    logic [lmr_pkg::SEL_W-1:0] low_group_sel_pair_2a, low_group_sel_pair_2b;
    logic [lmr_pkg::SEL_W-1:0] low_group_sel_pair_3a, low_group_sel_pair_3b;
    logic [lmr_pkg::SEL_W-1:0] low_group_sel_pair_4a, low_group_sel_pair_4b;
    logic [lmr_pkg::SEL_W-1:0] high_group_sel_pair_5a, high_group_sel_pair_5b;
    logic [lmr_pkg::SEL_W-1:0] high_group_sel_pair_6b;
    logic [lmr_pkg::NUM_PAIRS*lmr_pkg::SEL_W-1:0] code_vec;
    logic [lmr_pkg::NUM_PAIRS-1:0] pair_en;

    always_comb begin
        en_a1 = map_a1_ff[lmr_pkg::BIT_ENABLE]; // [RQ1]
        en_a2 = map_a2_ff[lmr_pkg::BIT_ENABLE]; // [RQ1]
        en_a3 = map_a3_ff[lmr_pkg::BIT_ENABLE]; // [RQ2]
        en_b1 = map_b1_ff[lmr_pkg::BIT_ENABLE]; // [RQ1]
        eff_a1 = en_a1 ? (map_a1_ff & lmr_pkg::FIELDS_WIDE) : '0; // [RQ1]
        eff_a2 = en_a2 ? (map_a2_ff & lmr_pkg::FIELDS_WIDE) : '0; // [RQ1]
        eff_a3 = en_a3 ? (map_a3_ff & lmr_pkg::FIELDS_NARROW) : '0; // [RQ2]
        eff_b1 = en_b1 ? (map_b1_ff & lmr_pkg::FIELDS_WIDE) : '0; // [RQ1]
    end

    // The high group packs its fields in a different order from the low group.
    always_comb begin
        low_group_sel_pair_1a = eff_a1[lmr_pkg::FLD_LO +: lmr_pkg::SEL_W]; // [RQ7]
        low_group_sel_pair_1b = eff_a1[lmr_pkg::FLD_MID +: lmr_pkg::SEL_W]; // [RQ6]
        low_group_sel_pair_2a = eff_a1[lmr_pkg::FLD_HI +: lmr_pkg::SEL_W]; // [RQ5]
        low_group_sel_pair_2b = eff_a2[lmr_pkg::FLD_LO +: lmr_pkg::SEL_W]; // [RQ8]
        low_group_sel_pair_3a = eff_a2[lmr_pkg::FLD_MID +: lmr_pkg::SEL_W]; // [RQ8]
        low_group_sel_pair_3b = eff_a2[lmr_pkg::FLD_HI +: lmr_pkg::SEL_W]; // [RQ8]
        low_group_sel_pair_4a = eff_a3[lmr_pkg::FLD_LO +: lmr_pkg::SEL_W]; // [RQ10]
        low_group_sel_pair_4b = eff_a3[lmr_pkg::FLD_MID +: lmr_pkg::SEL_W]; // [RQ9]
        high_group_sel_pair_5b = eff_b1[lmr_pkg::FLD_LO +: lmr_pkg::SEL_W]; // [RQ13]
        high_group_sel_pair_5a = eff_b1[lmr_pkg::FLD_MID +: lmr_pkg::SEL_W]; // [RQ12]
        high_group_sel_pair_6b = eff_b1[lmr_pkg::FLD_HI +: lmr_pkg::SEL_W]; // [RQ11]
    end

    always_comb begin
        code_vec = {high_group_sel_pair_6b, high_group_sel_pair_5b, high_group_sel_pair_5a,
                    low_group_sel_pair_4b, low_group_sel_pair_4a,
                    low_group_sel_pair_3b, low_group_sel_pair_3a, low_group_sel_pair_2b,
                    low_group_sel_pair_2a, low_group_sel_pair_1b, low_group_sel_pair_1a};
        pair_en = {{3{en_b1}}, {2{en_a3}}, {3{en_a2}}, {3{en_a1}}};
    end

    // Outputs are registered so each pair switches cleanly on one edge.
    logic [lmr_pkg::NUM_PAIRS*DATA_W-1:0] pair_data_ff, nxt_pair_data;
    logic [lmr_pkg::NUM_PAIRS*lmr_pkg::SEL_W-1:0] pair_sel_ff, nxt_pair_sel;

    genvar gp;
    generate
        for (gp = 0; gp < lmr_pkg::NUM_PAIRS; gp++) begin : g_pair
            logic [lmr_pkg::SEL_W-1:0] code;
            logic [1:0] ch;
            always_comb begin
                code = code_vec[gp*lmr_pkg::SEL_W +: lmr_pkg::SEL_W];
                ch = pair_en[gp] ? CODE_LUT[code*4 +: 2]
                                 : DEFAULT_SEL[gp*4 +: 2]; // [RQ14]
                nxt_pair_sel[gp*lmr_pkg::SEL_W +: lmr_pkg::SEL_W] = {2'h0, ch};
                if (gp >= lmr_pkg::PAIR_5A) begin
                    nxt_pair_data[gp*DATA_W +: DATA_W] = i_high_ch_data[ch*DATA_W +: DATA_W];
                end else begin
                    nxt_pair_data[gp*DATA_W +: DATA_W] = i_low_ch_data[ch*DATA_W +: DATA_W];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pair_data_ff <= '0;
            pair_sel_ff <= '0;
        end else begin
            pair_data_ff <= nxt_pair_data;
            pair_sel_ff <= nxt_pair_sel;
        end
    end

    assign o_pair_data = pair_data_ff;
    assign o_pair_sel = pair_sel_ff;

endmodule : lmr_lane_map

// ### verilog/lmr_pkg.sv
// How it works
// [RQ1] Registers 50h, 51h, 53h map bits 11:0 only while bit 15 is set.
// [RQ2] Lane_map_group_a_third maps bits 7:0 only while bit 15 is set.
// [RQ3] Software writes zero to bits 14:8 of lane_map_group_a_third.
// [RQ4] Software writes zero to bits 14:12 of registers 50h, 51h, 53h.
// [RQ5] Lane_map_group_a_first bits 11:8 pick the low channel for pair 2A.
// [RQ6] Lane_map_group_a_first bits 7:4 pick the low channel for pair 1B.
// [RQ7] Lane_map_group_a_first bits 3:0 pick the low channel for pair 1A.
// [RQ8] Lane_map_group_a_second bits 3:0, 7:4, 11:8 pick pairs 2B, 3A, 3B.
// [RQ9] Lane_map_group_a_third bits 7:4 pick the low channel for pair 4B.
// [RQ10] Lane_map_group_a_third bits 3:0 pick the low channel for pair 4A.
// [RQ11] Lane_map_group_b_first bits 11:8 pick the high channel for pair 6B.
// [RQ12] Lane_map_group_b_first bits 7:4 pick the high channel for pair 5A.
// [RQ13] Lane_map_group_b_first bits 3:0 pick the high channel for pair 5B.
// [RQ14] Disabled pairs carry default channel; code meaning is a configurable lookup.
package lmr_pkg;
    localparam int ADDR_W = 8;
    localparam int REG_W = 16;
    localparam int SEL_W = 4;
    localparam int NUM_PAIRS = 11;
    localparam logic [7:0] OFS_MAP_A1 = 8'h50;
    localparam logic [7:0] OFS_MAP_A2 = 8'h51;
    localparam logic [7:0] OFS_MAP_A3 = 8'h52;
    localparam logic [7:0] OFS_MAP_B1 = 8'h53;
    localparam int BIT_ENABLE = 15;
    localparam int FLD_LO = 0;
    localparam int FLD_MID = 4;
    localparam int FLD_HI = 8;
    localparam logic [15:0] RESET_VAL = 16'h0000;
    localparam logic [15:0] MASK_WIDE = 16'h8FFF;
    localparam logic [15:0] MASK_NARROW = 16'h80FF;
    localparam logic [15:0] FIELDS_WIDE = 16'h0FFF;
    localparam logic [15:0] FIELDS_NARROW = 16'h00FF;

    // Pair order on the output vectors.
    typedef enum logic [3:0] {
        PAIR_1A = 4'h0, PAIR_1B = 4'h1, PAIR_2A = 4'h2, PAIR_2B = 4'h3,
        PAIR_3A = 4'h4, PAIR_3B = 4'h5, PAIR_4A = 4'h6, PAIR_4B = 4'h7,
        PAIR_5A = 4'h8, PAIR_5B = 4'h9, PAIR_6B = 4'hA
    } lmr_pair_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0] wdata;
        logic wr;
        logic rd;
    } lmr_bus_t;
endpackage : lmr_pkg
